// ### hdl/ir_rx_pkg.sv
package ir_rx_pkg;
    // register byte addresses
    localparam logic [15:0] ADDR_CTRL = 16'hfec7;
    localparam logic [15:0] ADDR_EVT = 16'hfec8;
    localparam logic [15:0] ADDR_SFT = 16'hfec9;
    localparam logic [15:0] ADDR_RDT = 16'hfeca;
    localparam logic [15:0] ADDR_CTPR = 16'hfecb;
    localparam logic [15:0] ADDR_GPW = 16'hfecc;
    localparam logic [15:0] ADDR_D0W = 16'hfecd;
    localparam logic [15:0] ADDR_D1W = 16'hfece;
    localparam logic [15:0] ADDR_XHW = 16'hfecf;
    // control register fields
    localparam int CTRL_RUN = 7;
    localparam int CTRL_FMT = 4;
    localparam int CTRL_DINV = 3;
    // bit counter / prescale register fields
    localparam int CTPR_GPRE = 6;
    localparam int CTPR_DPRE = 4;
    localparam int CTPR_HOLD = 3;
    // high bits register: load direction
    localparam int XHW_DIR = 7;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_BCT = 3'h0;
    localparam logic [1:0] RST_PRE = 2'h0;
    // counter limits and the subclock select code
    localparam logic [2:0] BCT_LAST = 3'h7;
    localparam logic [1:0] NOISE_LAST = 2'h3;
    localparam logic [5:0] WIDTH_MAX = 6'h3f;
    localparam logic [2:0] CK_SUB = 3'h6;

    // receive formats; codes 5..7 are not allowed
    typedef enum logic [2:0] {
        FMT_A = 3'h0,
        FMT_B = 3'h1,
        FMT_C = 3'h2,
        FMT_D = 3'h3,
        FMT_E = 3'h4
    } fmt_t;

    // five bit width window, upper and lower limit
    typedef struct packed {
        logic [4:0] hi;
        logic [4:0] lo;
    } limit_t;

    // base clock divide in cycles per tick
    function automatic logic [6:0] base_div(input logic [2:0] sel);
        case (sel)
            3'h0: base_div = 7'h04;
            3'h1: base_div = 7'h08;
            3'h2: base_div = 7'h10;
            3'h3: base_div = 7'h20;
            3'h4: base_div = 7'h40;
            3'h5: base_div = 7'h00;
            default: base_div = 7'h01;
        endcase
    endfunction

    // prescale count; short table for manchester formats
    function automatic logic [5:0] pre_count(input logic [1:0] sel,
                                             input logic short_tbl);
        pre_count = short_tbl ? (6'h02 << sel) : (6'h04 << sel);
    endfunction

    // width lies in window: at least lo+1, below hi+1
    function automatic logic in_range(input logic [5:0] w,
                                      input limit_t lim);
        in_range = (w > {1'b0, lim.lo}) && (w <= {1'b0, lim.hi});
    endfunction
endpackage

// ### hdl/ir_pulse_timer.sv
`timescale 1ns/1ps
module ir_pulse_timer (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // setup
    input wire logic [2:0] ck_sel_in,
    input wire logic sub_tick_in,
    input wire logic [1:0] pre_sel_in,
    input wire logic short_pre_in,
    input wire logic restart_in,
    // results
    output logic base_tick_out,
    output logic [5:0] width_out
);
    import ir_rx_pkg::*;

    logic [6:0] div_cnt_ff; // base clock divider
    logic [4:0] pre_cnt_ff; // prescaler
    logic [5:0] width_ff; // saturating pulse width
    logic [6:0] div_last;
    logic [4:0] pre_last;
    logic pre_tick;

    // 128 wraps to zero in seven bits, so the last count is 127
    assign div_last = base_div(ck_sel_in) - 7'h01;
    assign pre_last = 5'(pre_count(pre_sel_in, short_pre_in) - 6'h01);
    // subclock ticks come from the synchronised pin edge
    assign base_tick_out = (ck_sel_in == CK_SUB) ? sub_tick_in :
                           (div_cnt_ff >= div_last);
    assign pre_tick = base_tick_out && (pre_cnt_ff >= pre_last);
    assign width_out = width_ff;

    // divider free runs except under the subclock select, which holds it at zero; >= keeps a select change from stalling it
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_cnt_ff <= 7'h00;
        end else if (base_tick_out || ck_sel_in == CK_SUB) begin
            div_cnt_ff <= 7'h00;
        end else begin
            div_cnt_ff <= div_cnt_ff + 7'h01;
        end
    end

    // prescaler and width counter restart at each measured edge
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pre_cnt_ff <= 5'h00;
            width_ff <= 6'h00;
        end else if (restart_in) begin
            pre_cnt_ff <= 5'h00;
            width_ff <= 6'h00;
        end else if (pre_tick) begin
            pre_cnt_ff <= 5'h00;
            // saturate so a long gap never looks short again
            if (width_ff != WIDTH_MAX) begin
                width_ff <= width_ff + 6'h01;
            end
        end else if (base_tick_out) begin
            pre_cnt_ff <= pre_cnt_ff + 5'h01;
        end
    end
endmodule // ir_pulse_timer

// ### hdl/ir_rx_core.sv
`timescale 1ns/1ps
// Function
// (RL1) data error flag set on bad pulse
// (RL2) event flags cleared only by software
// (RL3) enabled flag raises interrupt and hold release
// (RL4) full flag set on shift-to-data transfer
// (RL5) end flag set on end condition
// (RL6) guide flag never set in formats 2,3
// (RL7) bits shift in per direction bit
// (RL8) shift register cleared in four cases
// (RL9) data register unreset, changes only on transfer
// (RL10) software reads after end or full flag
// (RL11) 3-bit counter counts decoded bits
// (RL12) bit counter cleared on stop, guide, start
// (RL13) low four bits of counter register read-only
// (RL14) end of frame sets suspend, ignores input
// (RL15) shift register read lifts suspend
// (RL16) stopping clears the suspend flag
// (RL17) formats 0-2 prescale 4,8,16,32
// (RL18) formats 3,4 prescale 2,4,8,16
// (RL19) formats 2,3 ignore guide setup
// (RL20) guide register: upper nibble high, lower low
// (RL21) zero register: high and low limits
// (RL22) one register: high and low limits
// (RL23) run bit starts and stops receiver
// (RL24) format field selects five formats
// (RL25) direction 0 lsb first, 1 msb first
// (RL26) limits five bits with high-bit register
// (RL27) interrupt is a level while flags set
module ir_rx_core (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // register port
    input wire logic [15:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // pins
    input wire logic ir_pin_in,
    input wire logic sub_clk_in,
    // events
    output logic irq_out,
    output logic hold_release_out
);
    import ir_rx_pkg::*;

    // receiver states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_GUIDE = 4'b0010,
        ST_DATA = 4'b0100,
        ST_HOLD = 4'b1000
    } rx_state_t;

    // software setup
    logic run_ff; // receiver run bit
    logic [2:0] fmt_ff; // format select field
    logic dinv_ff; // input polarity
    logic [2:0] cksel_ff; // base clock select
    logic [3:0] evt_en_ff; // enables: guide, error, full, end
    logic [3:0] flag_ff; // flags in the same order
    logic [1:0] gpre_ff; // guide prescale select
    logic [1:0] dpre_ff; // data prescale select
    logic [7:0] gpw_ff; // guide width register
    logic [7:0] d0w_ff; // zero width register
    logic [7:0] d1w_ff; // one width register
    logic dir_ff; // load direction bit
    logic [5:0] xhi_ff; // fifth bits of the six limits
    // receive datapath
    logic [7:0] sft_ff; // receive shift register
    logic [7:0] rdt_ff; // receive data register
    logic rdt_loaded_ff; // set by the first transfer
    logic [2:0] bct_ff; // received bit counter
    rx_state_t state_ff;
    rx_state_t nxt_state;
    logic [7:0] rdata_ff;
    // input conditioning
    logic pin_meta_ff, pin_sync_ff;
    logic sub_meta_ff, sub_sync_ff, sub_last_ff;
    logic [1:0] flt_cnt_ff; // noise filter agreement count
    logic level_ff; // filtered, polarity corrected level
    logic level_last_ff;

    // decode wires
    logic wr_ctrl, wr_evt, wr_ctpr, rd_sft;
    logic guide_less, short_pre, in_hold;
    logic rise, fall, start_edge, meas_edge;
    logic base_tick, sub_tick, sample;
    logic [5:0] width;
    logic [1:0] pre_sel;
    logic restart;
    limit_t g_lim, d0_lim, d1_lim;
    logic guide_ok, bit_evt, bit_val, bad_bit, end_evt;
    logic clr_rx, xfer;
    logic [7:0] shifted;
    logic [3:0] set_vec;
    logic [3:0] nxt_flag;
    logic [7:0] rd_mux;

    // strobe decode
    assign wr_ctrl = wr_in && (addr_in == ADDR_CTRL);
    assign wr_evt = wr_in && (addr_in == ADDR_EVT);
    assign wr_ctpr = wr_in && (addr_in == ADDR_CTPR);
    assign rd_sft = rd_in && (addr_in == ADDR_SFT);

    // format classes
    assign guide_less = (fmt_ff == FMT_C) || (fmt_ff == FMT_D); // [RL24]
    assign short_pre = (fmt_ff == FMT_D) || (fmt_ff == FMT_E); // [RL18]
    assign in_hold = (state_ff == ST_HOLD);

    // five bit limits: fifth bit from the high-bits register
    assign g_lim = {xhi_ff[1], gpw_ff[7:4], xhi_ff[0], gpw_ff[3:0]}; // [RL20] [RL26]
    assign d0_lim = {xhi_ff[3], d0w_ff[7:4], xhi_ff[2], d0w_ff[3:0]}; // [RL21] [RL26]
    assign d1_lim = {xhi_ff[5], d1w_ff[7:4], xhi_ff[4], d1w_ff[3:0]}; // [RL22] [RL26]

    // pin synchronisers; the first stage is never looked at
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_meta_ff <= 1'b0;
            pin_sync_ff <= 1'b0;
            sub_meta_ff <= 1'b0;
            sub_sync_ff <= 1'b0;
            sub_last_ff <= 1'b0;
        end else begin
            pin_meta_ff <= ir_pin_in;
            pin_sync_ff <= pin_meta_ff;
            sub_meta_ff <= sub_clk_in;
            sub_sync_ff <= sub_meta_ff;
            sub_last_ff <= sub_sync_ff;
        end
    end

    assign sub_tick = sub_sync_ff && !sub_last_ff;
    assign sample = pin_sync_ff ^ dinv_ff;

    // noise filter: a new level must hold for four base ticks
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flt_cnt_ff <= 2'h0;
            level_ff <= 1'b0;
        end else if (!run_ff || sample == level_ff) begin
            flt_cnt_ff <= 2'h0;
        end else if (base_tick) begin
            flt_cnt_ff <= flt_cnt_ff + 2'h1;
            if (flt_cnt_ff == NOISE_LAST) begin
                level_ff <= sample;
            end
        end
    end

    // edge detect on the filtered level
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            level_last_ff <= 1'b0;
        end else begin
            level_last_ff <= level_ff;
        end
    end

    assign rise = level_ff && !level_last_ff;
    assign fall = !level_ff && level_last_ff;
    assign start_edge = rise;
    // format A measures the guide high time and data fall to fall
    assign meas_edge = (fmt_ff == FMT_A) ? fall : rise;

    // guide setup ignored in guide-less formats
    assign pre_sel = (state_ff == ST_GUIDE) ? gpre_ff : dpre_ff; // [RL19]
    assign restart = (nxt_state != state_ff) || meas_edge;

    // width timer with base divider and prescaler
    ir_pulse_timer u_timer (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ck_sel_in(cksel_ff),
        .sub_tick_in(sub_tick),
        .pre_sel_in(pre_sel), // [RL17] [RL18]
        .short_pre_in(short_pre),
        .restart_in(restart),
        .base_tick_out(base_tick),
        .width_out(width)
    );

    // pulse classification
    assign guide_ok = (state_ff == ST_GUIDE) && meas_edge
                      && in_range(width, g_lim);
    assign bit_evt = (state_ff == ST_DATA) && meas_edge
                     && (in_range(width, d0_lim) || in_range(width, d1_lim));
    assign bit_val = in_range(width, d1_lim);
    assign bad_bit = (state_ff == ST_DATA) && meas_edge && !bit_evt; // [RL1]
    // no edge past the upper one limit ends the frame
    assign end_evt = (state_ff == ST_DATA) && !meas_edge
                     && (width > {1'b0, d1_lim.hi}); // [RL5]

    // shift register clear on guide or first edge, and transfer
    assign clr_rx = guide_ok
                    || (state_ff == ST_IDLE && guide_less && start_edge);
    assign xfer = bit_evt && (bct_ff == BCT_LAST);
    assign shifted = dir_ff ? {sft_ff[6:0], bit_val} :
                     {bit_val, sft_ff[7:1]}; // [RL7] [RL25]

    // next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (start_edge) begin
                    nxt_state = guide_less ? ST_DATA : ST_GUIDE;
                end
            end
            ST_GUIDE: begin
                // a failed guide just waits for the next one
                if (meas_edge) begin
                    nxt_state = guide_ok ? ST_DATA : ST_IDLE;
                end
            end
            ST_DATA: begin
                if (bad_bit) begin
                    nxt_state = ST_IDLE;
                end else if (end_evt) begin
                    nxt_state = ST_HOLD; // [RL14]
                end
            end
            ST_HOLD: begin
                // input ignored until the shift register is read
                if (rd_sft) begin
                    nxt_state = ST_IDLE; // [RL15]
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (!run_ff) begin
            nxt_state = ST_IDLE; // [RL16] [RL23]
        end
    end

    // state register; the hold state is the suspend flag
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // event sets; guide flag only in formats with a guide
    assign set_vec = {guide_ok && !guide_less, bad_bit, xfer, end_evt}; // [RL6]
    // a set in the clearing cycle wins over the write
    assign nxt_flag = (wr_evt ? {wdata_in[7], wdata_in[5],
                       wdata_in[3], wdata_in[1]} : flag_ff)
                      | set_vec; // [RL2] [RL4]

    // event flags and enables
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flag_ff <= 4'h0;
            evt_en_ff <= 4'h0;
        end else begin
            flag_ff <= nxt_flag; // [RL1] [RL5]
            if (wr_evt) begin
                evt_en_ff <= {wdata_in[6], wdata_in[4],
                              wdata_in[2], wdata_in[0]};
            end
        end
    end

    // one shared level request while any enabled flag is set
    assign irq_out = |(flag_ff & evt_en_ff); // [RL3] [RL27]
    assign hold_release_out = |(flag_ff & evt_en_ff); // [RL3]

    // shift register and bit counter
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sft_ff <= RST_BYTE;
            bct_ff <= RST_BCT;
        end else if (!run_ff || clr_rx) begin
            sft_ff <= RST_BYTE; // [RL8]
            bct_ff <= RST_BCT; // [RL12]
        end else if (bit_evt) begin
            // counter wraps to zero as the byte moves on
            sft_ff <= xfer ? RST_BYTE : shifted; // [RL8]
            bct_ff <= bct_ff + 3'h1; // [RL11]
        end
    end

    // data register has no reset; loaded only by a full byte
    always_ff @(posedge clk_in) begin
        if (xfer) begin
            rdt_ff <= shifted; // [RL9] [RL4]
        end
    end

    // stability of the data register means nothing until it is loaded
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdt_loaded_ff <= 1'b0;
        end else if (xfer) begin
            rdt_loaded_ff <= 1'b1;
        end
    end

    // control, prescale and width setup
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            run_ff <= 1'b0;
            fmt_ff <= 3'h0;
            dinv_ff <= 1'b0;
            cksel_ff <= 3'h0;
            gpre_ff <= RST_PRE;
            dpre_ff <= RST_PRE;
            gpw_ff <= RST_BYTE;
            d0w_ff <= RST_BYTE;
            d1w_ff <= RST_BYTE;
            dir_ff <= 1'b0;
            xhi_ff <= 6'h00;
        end else if (wr_in) begin
            if (wr_ctrl) begin
                run_ff <= wdata_in[CTRL_RUN]; // [RL23]
                fmt_ff <= wdata_in[CTRL_FMT +: 3];
                dinv_ff <= wdata_in[CTRL_DINV];
                cksel_ff <= wdata_in[2:0];
            end
            // only the prescale selects take writes here
            if (wr_ctpr) begin
                gpre_ff <= wdata_in[CTPR_GPRE +: 2]; // [RL13]
                dpre_ff <= wdata_in[CTPR_DPRE +: 2];
            end
            if (addr_in == ADDR_GPW) begin
                gpw_ff <= wdata_in;
            end
            if (addr_in == ADDR_D0W) begin
                d0w_ff <= wdata_in;
            end
            if (addr_in == ADDR_D1W) begin
                d1w_ff <= wdata_in;
            end
            if (addr_in == ADDR_XHW) begin
                dir_ff <= wdata_in[XHW_DIR];
                xhi_ff <= wdata_in[5:0];
            end
        end
    end

    // read selection; unmapped addresses read zero
    always_comb begin
        case (addr_in)
            ADDR_CTRL: rd_mux = {run_ff, fmt_ff, dinv_ff, cksel_ff};
            ADDR_EVT: rd_mux = {flag_ff[3], evt_en_ff[3], flag_ff[2],
                                evt_en_ff[2], flag_ff[1], evt_en_ff[1],
                                flag_ff[0], evt_en_ff[0]};
            ADDR_SFT: rd_mux = sft_ff;
            ADDR_RDT: rd_mux = rdt_ff;
            ADDR_CTPR: rd_mux = {gpre_ff, dpre_ff, in_hold, bct_ff};
            ADDR_GPW: rd_mux = gpw_ff;
            ADDR_D0W: rd_mux = d0w_ff;
            ADDR_D1W: rd_mux = d1w_ff;
            ADDR_XHW: rd_mux = {dir_ff, 1'b0, xhi_ff};
            default: rd_mux = RST_BYTE;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_ff <= RST_BYTE;
        end else begin
            rdata_ff <= rd_in ? rd_mux : RST_BYTE;
        end
    end

    assign rdata_out = rdata_ff;

    // error flag stays up until a write to the event register
    chk_err_flag_sticky: assert property ( // [RL1] [RL2]
        @(posedge clk_in) disable iff (!nrst_in)
        flag_ff[2] && !wr_evt |=> flag_ff[2])
        else $error("error flag dropped without a write");

    // set beats a clearing write in the same cycle
    chk_flag_set_wins: assert property ( // [RL2]
        @(posedge clk_in) disable iff (!nrst_in)
        wr_evt && bad_bit |=> flag_ff[2])
        else $error("error flag lost to a clearing write");

    // enabled full flag keeps both request outputs high
    chk_irq_level: assert property ( // [RL3] [RL27]
        @(posedge clk_in) disable iff (!nrst_in)
        xfer && evt_en_ff[1] && !wr_evt |=> irq_out && hold_release_out)
        else $error("interrupt missing after enabled transfer");

    // transfer sets full flag and loads the data register
    chk_full_on_xfer: assert property ( // [RL4] [RL9]
        @(posedge clk_in) disable iff (!nrst_in)
        xfer |=> flag_ff[1] && rdt_ff == $past(shifted) && sft_ff == 8'h00)
        else $error("transfer did not load data and set full");

    // end of frame sets end flag and suspends
    chk_end_suspends: assert property ( // [RL5] [RL14]
        @(posedge clk_in) disable iff (!nrst_in)
        end_evt && run_ff |=> flag_ff[0] && in_hold ##1 in_hold || !run_ff
        || $past(rd_sft))
        else $error("end of frame did not suspend");

    // no guide flag set in guide-less formats
    chk_no_guide_flag: assert property ( // [RL6]
        @(posedge clk_in) disable iff (!nrst_in)
        guide_less && !flag_ff[3] && !wr_evt |=> !flag_ff[3])
        else $error("guide flag set without a guide");

    // data register holds between transfers
    chk_rdt_stable: assert property ( // [RL9]
        @(posedge clk_in) disable iff (!nrst_in)
        rdt_loaded_ff && !xfer |=> $stable(rdt_ff))
        else $error("data register changed without transfer");

    // bit counter advances by one on each decoded bit
    chk_bct_count: assert property ( // [RL11]
        @(posedge clk_in) disable iff (!nrst_in)
        bit_evt && run_ff |=> bct_ff == $past(bct_ff) + 3'h1)
        else $error("bit counter did not advance");

    // stopping clears shift register, counter and suspend
    chk_stop_clears: assert property ( // [RL8] [RL12] [RL16]
        @(posedge clk_in) disable iff (!nrst_in)
        !run_ff |=> sft_ff == 8'h00 && bct_ff == 3'h0 && !in_hold)
        else $error("stop left receive state behind");

    // a write cannot change the counter bits
    chk_ro_counter: assert property ( // [RL13]
        @(posedge clk_in) disable iff (!nrst_in)
        wr_ctpr && !bit_evt && !clr_rx && run_ff |=> $stable(bct_ff))
        else $error("counter bits changed by a write");

    // reading the shift register lifts the suspension
    chk_read_resumes: assert property ( // [RL15]
        @(posedge clk_in) disable iff (!nrst_in)
        in_hold && rd_sft |=> state_ff == ST_IDLE)
        else $error("suspension not lifted by read");
endmodule // ir_rx_core

// ### testbench/ir_remote_model.sv
`timescale 1ns/1ps
// far-side remote transmitter; the line idles low between frames
module ir_remote_model (
    // clock
    input wire logic clk_in,
    // remote line
    output logic ir_out
);
    initial ir_out = 1'b0;
    // mark of h cycles, then space of l cycles; keep both above the
    // filter span so no edge is eaten as noise
    task automatic pulse(input int h, input int l);
        @(posedge clk_in) ir_out <= 1'b1;
        repeat (h) @(posedge clk_in);
        ir_out <= 1'b0;
        repeat (l - 1) @(posedge clk_in);
    endtask
endmodule // ir_remote_model

// ### testbench/tb_ir_remote_receive_regs.sv
`timescale 1ns/1ps
module tb_ir_remote_receive_regs;
    import ir_rx_pkg::*;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [15:0] addr_in = 16'h0000;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rdata_out;
    logic ir_line; // remote line from the model
    logic irq_out;
    logic hold_release_out;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0; // hang guard
    integer seed = 32'ha304_5aa2;

    always #20 clk_in = ~clk_in;

    // subclock pin: one rising edge every two cycles
    logic sub_clk = 1'b0;
    always @(posedge clk_in) sub_clk <= ~sub_clk;

    // subclock only matters in the last case, base select 6
    ir_rx_core ir_rx_core_inst (.clk_in(clk_in), .nrst_in(nrst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .ir_pin_in(ir_line),
        .sub_clk_in(sub_clk), .irq_out(irq_out),
        .hold_release_out(hold_release_out));
    ir_remote_model ir_remote_model_inst (.clk_in(clk_in),
        .ir_out(ir_line));

    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle write; #1 lets the register update land
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out, e);
    endtask

    // {data register, shift register} after n bits
    function automatic logic [15:0] expect_rx(input logic [15:0] bits,
                                              input int n,
                                              input logic dir);
        logic [7:0] s;
        logic [7:0] d;
        s = 8'h00;
        d = 8'h00;
        for (int i = 0; i < n; i++) begin
            s = dir ? {s[6:0], bits[i]} : {bits[i], s[7:1]};
            if (i % 8 == 7) begin
                d = s;
                s = 8'h00;
            end
        end
        return {d, s};
    endfunction

    // guide 7 ticks, zero 3, one 8; format 0 ends guide on its fall
    task automatic frame(input logic [2:0] f, input logic [15:0] bits,
                         input int n);
        if (f != 3'h2 && f != 3'h3) begin
            ir_remote_model_inst.pulse(f == 3'h0 ? 28 : 22, 6);
        end
        for (int i = 0; i < n; i++) begin
            ir_remote_model_inst.pulse(bits[i] ? 26 : 6, 6);
        end
        // rising-edge formats need a closing edge for the last bit
        if (f != 3'h0) begin
            ir_remote_model_inst.pulse(6, 6);
        end
        repeat (100) @(posedge clk_in);
    endtask

    task automatic stop_test;
        if (fails == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            fails = fails + 1;
            stop_test;
        end
    end

    initial begin
        logic [15:0] bits;
        logic [15:0] e;
        logic [7:0] d;
        logic [1:0] p;
        int n;
        repeat (3) @(posedge clk_in);
        nrst_in <= 1'b1;
        // reset values; 0xfed0 is unmapped
        for (int a = 16'hfec7; a <= 16'hfed0; a++) begin
            if (a != 16'hfeca) rd(a[15:0], 8'h00);
        end
        for (int a = 16'hfecc; a <= 16'hfece; a++) begin
            d = 8'($random(seed));
            wr(a[15:0], d);
            rd(a[15:0], d);
        end
        wr(ADDR_CTPR, 8'hff);
        rd(ADDR_CTPR, 8'hf0);
        wr(ADDR_SFT, 8'hff);
        rd(ADDR_SFT, 8'h00);
        // every format, alternating load direction
        for (int f = 0; f < 5; f++) begin
            p = (f > 2) ? 2'h1 : 2'h0;
            n = 8 + ($random(seed) & 7);
            bits = 16'($random(seed));
            e = expect_rx(bits, n, f[0]);
            wr(ADDR_CTPR, {p, p, 4'h0});
            wr(ADDR_GPW, (f == 2 || f == 3) ? 8'h00 : 8'ha4);
            wr(ADDR_D0W, 8'h41);
            wr(ADDR_D1W, 8'ha6);
            wr(ADDR_XHW, {f[0], 7'h00});
            wr(ADDR_EVT, 8'h55);
            wr(ADDR_CTRL, {1'b1, f[2:0], 4'h7});
            frame(f[2:0], bits, n);
            rd(ADDR_EVT, (f == 2 || f == 3) ? 8'h5f : 8'hdf);
            chk(irq_out, 8'h01);
            chk(hold_release_out, 8'h01);
            rd(ADDR_RDT, e[15:8]);
            rd(ADDR_CTPR, {p, p, 1'b1, n[2:0]});
            rd(ADDR_SFT, e[7:0]);
            rd(ADDR_CTPR, {p, p, 1'b0, n[2:0]});
            wr(ADDR_EVT, 8'h55);
            rd(ADDR_EVT, 8'h55);
            chk(irq_out, 8'h00);
            wr(ADDR_CTRL, 8'h00);
            rd(ADDR_CTPR, {p, p, 4'h0});
        end
        // bad data width after a good guide
        wr(ADDR_CTPR, 8'h00);
        wr(ADDR_GPW, 8'ha4);
        wr(ADDR_EVT, 8'h10);
        wr(ADDR_CTRL, 8'h97);
        ir_remote_model_inst.pulse(22, 6);
        ir_remote_model_inst.pulse(16, 6);
        ir_remote_model_inst.pulse(6, 6);
        repeat (100) @(posedge clk_in);
        rd(ADDR_EVT, 8'hb0);
        chk(irq_out, 8'h01);
        wr(ADDR_EVT, 8'ha0);
        chk(irq_out, 8'h00);
        // subclock base ticks: format 2, one byte, msb first
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_XHW, 8'h80);
        wr(ADDR_EVT, 8'h55);
        wr(ADDR_CTRL, 8'ha6);
        e = expect_rx(16'h0055, 8, 1'b1);
        // even periods keep every edge on the same tick phase
        for (int i = 0; i < 9; i++) begin
            ir_remote_model_inst.pulse((i < 8 && !i[0]) ? 56 : 16, 12);
        end
        repeat (150) @(posedge clk_in);
        rd(ADDR_EVT, 8'h5f);
        rd(ADDR_RDT, e[15:8]);
        rd(ADDR_CTPR, 8'h08);
        stop_test;
    end
endmodule // tb_ir_remote_receive_regs
